// [verilog/ebt_timer.v]
// Top of the eight-bit timer/counter: register port, instruction phase, count core, flag and interrupt.
// Assumes a one-cycle read/write strobe master and inputs synchronous to clk except the count pin.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "ebt_consts.vh"
module ebt_timer (
  input  wire       clk,                  // System clock, 40 MHz.
  input  wire       rst_n,                // Synchronous reset, active low.
  input  wire [3:0] addr,                 // Register address.
  input  wire [7:0] wdata,                // Write data.
  input  wire       wr_en,                // Write strobe, one cycle.
  input  wire       rd_en,                // Read strobe, one cycle.
  output reg  [7:0] rdata,                // Read data, valid the cycle after rd_en.
  input  wire       sleep,                // Processor sleep level.
  input  wire       external_count_input, // External count pin.
  output reg        irq,                  // Level interrupt.
  output reg        overflow_gate         // One-cycle overflow pulse for the 16-bit timer gate.
);
  reg  [7:0] timer_count;
  reg        clock_source_select;
  reg        source_edge_select;
  reg        prescaler_bypass;
  reg  [2:0] prescale_rate;
  reg        overflow_flag;
  reg        overflow_irq_enable;
  reg        event_status;
  reg        event_mask;
  reg  [1:0] quarter;
  reg  [1:0] inhibit;
  reg        pre_last;
  reg        pre_sample;
  wire       pin_edge;
  wire       pre_level;
  wire       instr_tick;
  wire       source_tick;
  wire       pre_tick;
  wire       count_tick;
  wire       wrap;
  wire       count_wr;

  // Decodes a strobe at one register address.
  function hit;
    input [3:0] a;
    input [3:0] target;
    input       strobe;
    begin
      hit = strobe & (a == target);
    end
  endfunction

  assign count_wr = hit(addr, `EBT_ADDR_COUNT, wr_en);

  // Instruction cycle is four clock quarters; a tick ends each cycle.
  always @(posedge clk)
  begin
    if (!rst_n)
      quarter <= 2'h0;
    else
      quarter <= quarter + 2'h1;
  end

  assign instr_tick = (quarter == `EBT_Q4);

  ebt_edge_sync u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (external_count_input),
    .falling   (source_edge_select),
    .edge_seen (pin_edge)
  );

  // source select picks the count source.
  assign source_tick = sleep ? 1'b0 : (clock_source_select ? pin_edge : instr_tick);

  ebt_prescaler #(
    .WIDTH (8)
  ) u_pre (
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (count_wr),
    .tick      (source_tick),
    .rate      (prescale_rate),
    .out_level (pre_level)
  );

  // prescaler output sampled at quarters two and four.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pre_sample <= 1'b0;
      pre_last   <= 1'b0;
    end
    else if (quarter == `EBT_Q2 || quarter == `EBT_Q4)
    begin
      pre_sample <= pre_level;
      pre_last   <= pre_sample;
    end
  end

  // falling edge of the divided tap is one prescaled count.
  // tap choice follows the rate field.
  assign pre_tick = pre_last & ~pre_sample & ((quarter == `EBT_Q2) | (quarter == `EBT_Q4)) & ~sleep;

  // bypass gives 1:1, otherwise the prescaler.
  assign count_tick = (prescaler_bypass ? source_tick : pre_tick) & (inhibit == 2'h0);

  assign wrap = count_tick & (timer_count == 8'hFF);

  // two instruction cycles of hold-off after a count write.
  always @(posedge clk)
  begin
    if (!rst_n)
      inhibit <= 2'h0;
    else if (count_wr)
      inhibit <= `EBT_INHIBIT_CYCLES;
    else if (instr_tick && inhibit != 2'h0)
      inhibit <= inhibit - 2'h1;
  end

  // no tick in sleep keeps the value.
  always @(posedge clk)
  begin
    if (!rst_n)
      timer_count <= 8'h00;
    else if (count_wr)
      timer_count <= wdata;
    else if (count_tick)
      timer_count <= timer_count + 8'h01;
  end

  // Option bits reset to all ones, the bypass set and external source selected.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      clock_source_select <= 1'b1;
      source_edge_select  <= 1'b1;
      prescaler_bypass    <= 1'b1;
      prescale_rate       <= 3'h7;
    end
    else if (hit(addr, `EBT_ADDR_OPTION, wr_en))
    begin
      clock_source_select <= wdata[`EBT_OPT_SOURCE];
      source_edge_select  <= wdata[`EBT_OPT_EDGE];
      prescaler_bypass    <= wdata[`EBT_OPT_BYPASS];
      prescale_rate       <= wdata[`EBT_OPT_RATE_HI:`EBT_OPT_RATE_LO];
    end
  end

  // Interrupt control, flag, sticky status and mask; a wrap wins over a clear.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      overflow_flag       <= 1'b0;
      overflow_irq_enable <= 1'b0;
      event_status        <= 1'b0;
      event_mask          <= 1'b0;
    end
    else
    begin
      if (hit(addr, `EBT_ADDR_INTCTL, wr_en))
        overflow_irq_enable <= wdata[`EBT_INT_ENABLE];
      if (wrap)
        overflow_flag <= 1'b1;
      else if (hit(addr, `EBT_ADDR_INTCTL, wr_en))
        overflow_flag <= wdata[`EBT_INT_FLAG];
      if (wrap)
        event_status <= 1'b1;
      else if (hit(addr, `EBT_ADDR_STATUS, wr_en) && wdata[`EBT_STS_OVF])
        event_status <= 1'b0;
      if (hit(addr, `EBT_ADDR_MASK, wr_en))
        event_mask <= wdata[`EBT_STS_OVF];
    end
  end

  // interrupt from flag and enable, or from the status copy with its mask set.
  // overflow pulse offered to the 16-bit timer gate.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq           <= 1'b0;
      overflow_gate <= 1'b0;
    end
    else
    begin
      irq           <= (overflow_flag & overflow_irq_enable) | (event_status & event_mask);
      overflow_gate <= wrap;
    end
  end

  // read mux; unmapped addresses read zero.
  always @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd_en)
    begin
      case (addr)
        `EBT_ADDR_COUNT:  rdata <= timer_count;
        `EBT_ADDR_OPTION: rdata <= {2'h0, clock_source_select, source_edge_select, prescaler_bypass, prescale_rate};
        `EBT_ADDR_INTCTL: rdata <= {2'h0, overflow_irq_enable, 2'h0, overflow_flag, 2'h0};
        `EBT_ADDR_STATUS: rdata <= {7'h00, event_status};
        `EBT_ADDR_MASK:   rdata <= {7'h00, event_mask};
        default:          rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule // ebt_timer

// [inc/ebt_consts.vh]
// Constants for the eight-bit timer/counter: register offsets, field positions, reset values, timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef EBT_CONSTS_VH
`define EBT_CONSTS_VH
`define EBT_ADDR_COUNT      4'h0
`define EBT_ADDR_OPTION     4'h1
`define EBT_ADDR_INTCTL     4'h2
`define EBT_ADDR_STATUS     4'h3
`define EBT_ADDR_MASK       4'h4
`define EBT_OPT_RATE_LO     0
`define EBT_OPT_RATE_HI     2
`define EBT_OPT_BYPASS      3
`define EBT_OPT_EDGE        4
`define EBT_OPT_SOURCE      5
`define EBT_OPT_RESET       8'h3F
`define EBT_INT_FLAG        2
`define EBT_INT_ENABLE      5
`define EBT_STS_OVF         0
`define EBT_INHIBIT_CYCLES  2'h2
`define EBT_QUARTERS        4
`define EBT_Q2              2'h1
`define EBT_Q4              2'h3
`endif

// [verilog/ebt_prescaler.v]
// Dedicated 3-bit rate prescaler: a ripple-free divider whose tap is picked by the rate field.
// Assumes count pulses one clock wide and a synchronous clear from the timer core.
`timescale 1ns/1ps
module ebt_prescaler #(
  parameter WIDTH = 8                     // Divider stages.
) (
  input  wire       clk,                  // System clock.
  input  wire       rst_n,                // Synchronous reset, active low.
  input  wire       clear,                // Clears the hidden count.
  input  wire       tick,                 // Input event pulse.
  input  wire [2:0] rate,                 // Rate select, 000 divides by 2.
  output reg        out_level             // Selected divider tap.
);
  reg  [WIDTH-1:0] div;
  reg  [WIDTH-1:0] next_div;

  // Next divider value; the count is never visible to software.
  always @*
  begin
    next_div = div;
    if (clear)
      next_div = {WIDTH{1'b0}};
    else if (tick)
      next_div = div + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  // Holds the divider and picks tap rate, so 000 gives 1:2 and 111 gives 1:256.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div       <= {WIDTH{1'b0}};
      out_level <= 1'b0;
    end
    else
    begin
      div       <= next_div;
      out_level <= next_div[rate];
    end
  end
endmodule // ebt_prescaler

// [verilog/ebt_edge_sync.v]
// Two-stage synchroniser and edge picker for the external count pin.
// Assumes the pin is a plain level; only the second stage is read.
`timescale 1ns/1ps
module ebt_edge_sync (
  input  wire clk,                        // System clock.
  input  wire rst_n,                      // Synchronous reset, active low.
  input  wire pin,                        // External count input.
  input  wire falling,                    // High selects falling edges.
  output reg  edge_seen                   // One-cycle pulse per chosen edge.
);
  reg stage1;
  reg stage2;
  reg last;

  // Synchronise, then compare the settled level with its previous value.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1    <= 1'b0;
      stage2    <= 1'b0;
      last      <= 1'b0;
      edge_seen <= 1'b0;
    end
    else
    begin
      stage1    <= pin;
      stage2    <= stage1;
      last      <= stage2;
      edge_seen <= falling ? (last & ~stage2) : (~last & stage2);
    end
  end
endmodule // ebt_edge_sync

// [test/ebt_timer_asserts.sv]
// Port-level checker for the eight-bit timer/counter.
// Assumes it is bound to ebt_timer and sees only its ports.
`timescale 1ns/1ps
`include "ebt_consts.vh"
module ebt_timer_asserts (
  input wire       clk,          // Clock.
  input wire       rst_n,        // Reset, active low.
  input wire [3:0] addr,         // Address.
  input wire [7:0] wdata,        // Write data.
  input wire       wr_en,        // Write strobe.
  input wire       rd_en,        // Read strobe.
  input wire [7:0] rdata,        // Read data.
  input wire       sleep,        // Sleep level.
  input wire       irq,          // Interrupt.
  input wire       overflow_gate // Overflow pulse.
);
  reg       en_sh;   // Last written overflow enable.
  reg       mask_sh; // Last written mask bit.
  reg [7:0] cnt_sh;  // Last value written to the count.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadows of what software last wrote, so irq can be tied to its cause.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      en_sh   <= 1'b0;
      mask_sh <= 1'b0;
      cnt_sh  <= 8'h00;
    end
    else if (wr_en)
    begin
      if (addr == `EBT_ADDR_INTCTL)
        en_sh <= wdata[`EBT_INT_ENABLE];
      if (addr == `EBT_ADDR_MASK)
        mask_sh <= wdata[0];
      if (addr == `EBT_ADDR_COUNT)
        cnt_sh <= wdata;
    end
  end
  sequence s_cnt_wr;
    wr_en && addr == `EBT_ADDR_COUNT;
  endsequence
  sequence s_cnt_rd;
    rd_en && addr == `EBT_ADDR_COUNT;
  endsequence
  chk_count_readback: assert property (s_cnt_wr ##1 s_cnt_rd |=> rdata == cnt_sh)
    else $error("count readback differs from written value");
  chk_write_inhibit: assert property (s_cnt_wr |-> ##2 !overflow_gate[*3])
    else $error("overflow right after a count write");
  chk_unmapped_zero: assert property (rd_en && addr > `EBT_ADDR_MASK |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_idle: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data outside a read");
  chk_gate_single: assert property (overflow_gate |=> !overflow_gate)
    else $error("overflow pulse longer than one cycle");
  chk_gate_irq: assert property (overflow_gate && en_sh |-> ##[0:2] irq)
    else $error("enabled overflow gave no interrupt");
  chk_irq_off: assert property ((!en_sh && !mask_sh)[*3] |-> !irq)
    else $error("interrupt while all sources disabled");
  chk_sleep_quiet: assert property (sleep[*8] |-> !overflow_gate)
    else $error("overflow during sleep");
endmodule // ebt_timer_asserts
bind ebt_timer ebt_timer_asserts ebt_timer_asserts_inst (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
  .sleep, .irq, .overflow_gate);

// [test/testbench.sv]
// Bench for the eight-bit timer/counter, checked against counts worked out here.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
`include "ebt_consts.vh"
module testbench;
  logic       clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, sleep = 1'b0, pin = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, v, a0;
  wire  [7:0] rdata;
  wire        irq, ovf;
  int         err_count = 0, num_checks = 0, cyc = 0, gates = 0, n;
  ebt_timer ebt_timer_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .sleep(sleep), .external_count_input(pin), .irq(irq), .overflow_gate(ovf));
  // Free-running 40 MHz clock.
  initial forever #12.5 clk = ~clk;
  // Compares one result and counts it.
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    rd_en <= 1'b0;
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  // Read strobe for one cycle; data taken in the following cycle.
  task rd(input logic [3:0] a);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  task idle(input int k);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (k) @(posedge clk);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Counts overflow pulses and cuts a hang short.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (ovf === 1'b1)
      gates <= gates + 1;
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end
  initial
  begin
    v = 8'($urandom(32'h12CEBAED));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`EBT_ADDR_OPTION);
    check("option", v, `EBT_OPT_RESET);
    wr(4'hF, 8'($urandom));
    rd(4'hF);
    check("unmapped", v, 8'h00);
    $display("test reset done");
    // Timer mode: a write reads back at once, then one count per four clocks.
    wr(`EBT_ADDR_OPTION, 8'h08);
    wr(`EBT_ADDR_COUNT, 8'hFE);
    rd(`EBT_ADDR_COUNT);
    check("readback", v, 8'hFE);
    idle(10);
    rd(`EBT_ADDR_COUNT);
    a0 = v;
    idle(38);
    rd(`EBT_ADDR_COUNT);
    check("timer rate", v, 8'(a0 + 10));
    rd(`EBT_ADDR_INTCTL);
    check("flag", v, 8'h04);
    check("irq off", {7'h00, irq}, 8'h00);
    check("gate", {7'h00, gates > 0}, 8'h01);
    wr(`EBT_ADDR_MASK, 8'h01);
    idle(3);
    check("irq mask", {7'h00, irq}, 8'h01);
    wr(`EBT_ADDR_STATUS, 8'h01);
    rd(`EBT_ADDR_STATUS);
    check("status clear", v, 8'h00);
    wr(`EBT_ADDR_INTCTL, 8'h24);
    idle(99);
    rd(`EBT_ADDR_INTCTL);
    check("flag held", v, 8'h24);
    check("irq enable", {7'h00, irq}, 8'h01);
    wr(`EBT_ADDR_COUNT, 8'hFF);
    idle(16);
    wr(`EBT_ADDR_INTCTL, 8'h00);
    wr(`EBT_ADDR_MASK, 8'h00);
    idle(3);
    check("irq clear", {7'h00, irq}, 8'h00);
    $display("test timer done");
    // Each prescale rate gives two counts in twice its period.
    for (int r = 0; r < 8; r++)
    begin
      wr(`EBT_ADDR_OPTION, 8'(r));
      wr(`EBT_ADDR_COUNT, 8'h00);
      idle(12);
      rd(`EBT_ADDR_COUNT);
      a0 = v;
      idle((16 << r) - 2);
      rd(`EBT_ADDR_COUNT);
      check("prescale", v, 8'(a0 + 2));
    end
    $display("test prescale done");
    // Sleep freezes the count.
    wr(`EBT_ADDR_OPTION, 8'h08);
    sleep <= 1'b1;
    idle(8);
    rd(`EBT_ADDR_COUNT);
    a0 = v;
    idle(38);
    rd(`EBT_ADDR_COUNT);
    check("sleep hold", v, a0);
    sleep <= 1'b0;
    $display("test sleep done");
    // Pin edges: n rising and n-1 falling, so polarity shows in the count.
    for (int e = 0; e < 2; e++)
    begin
      wr(`EBT_ADDR_OPTION, e ? 8'h38 : 8'h28);
      pin <= 1'b0;
      idle(8);
      wr(`EBT_ADDR_COUNT, 8'h00);
      idle(12);
      n = $urandom_range(6, 2);
      repeat (n - 1)
      begin
        pin <= 1'b1;
        idle(8);
        pin <= 1'b0;
        idle(8);
      end
      pin <= 1'b1;
      idle(16);
      rd(`EBT_ADDR_COUNT);
      check("edges", v, 8'(e ? n - 1 : n));
    end
    $display("test counter done");
    give_verdict();
  end
endmodule // testbench
